// ==== core/rtc_pkg.sv ====
// Shared constants and types for the real-time clock output and access block
package rtc_pkg;

  // ==========================================================================
  // Serial slave identity
  // ==========================================================================
  // Arbitrary seven-bit control code; set the real one at integration
  localparam logic [6:0] RTC_DEV_ADDR_DEF   = 7'h5A;
  localparam logic [3:0] RTC_BITS_PER_BYTE  = 4'h8;
  localparam logic [3:0] RTC_LAST_TX_BIT    = 4'h7;

  // ==========================================================================
  // Register and memory map (word addresses)
  // ==========================================================================
  localparam logic [6:0] RTC_ADDR_STATUS    = 7'h03;
  localparam logic [6:0] RTC_ADDR_CONTROL   = 7'h07;
  localparam logic [6:0] RTC_ADDR_CALIB     = 7'h08;
  localparam logic [6:0] RTC_ADDR_FAIL_REC  = 7'h18;
  localparam logic [6:0] RTC_ADDR_REST_REC  = 7'h1C;
  localparam logic [6:0] RTC_ADDR_CLK_FIRST = 7'h00;
  localparam logic [6:0] RTC_ADDR_CLK_LAST  = 7'h1F;
  localparam logic [6:0] RTC_ADDR_SRAM_BASE = 7'h20;
  localparam logic [6:0] RTC_ADDR_SRAM_LAST = 7'h5F;
  localparam logic [7:0] RTC_ADDR_MAX       = 8'h5F;
  localparam int unsigned RTC_MEM_WORDS     = 96;

  // ==========================================================================
  // Field positions and reset values
  // ==========================================================================
  localparam int unsigned RTC_BIT_BATTERY   = 4;
  localparam int unsigned RTC_BIT_OUT_LEVEL = 7;
  localparam int unsigned RTC_BIT_SQUARE_WAVE_ENABLE      = 6;
  localparam int unsigned RTC_BIT_ALARM_HI  = 5;
  localparam int unsigned RTC_BIT_ALARM_LO  = 4;
  localparam int unsigned RTC_BIT_CAL_SIGN  = 7;
  localparam logic [7:0]  RTC_CONTROL_RST   = 8'h00;
  localparam logic [7:0]  RTC_CALIB_RST     = 8'h00;
  localparam logic [31:0] RTC_RECORD_RST    = 32'h0000_0000;

  // ==========================================================================
  // Oscillator periods, in oscillator input cycles
  // ==========================================================================
  localparam int unsigned RTC_OSC_HZ        = 32768;
  localparam int unsigned RTC_MINUTE_S      = 60;
  localparam int unsigned RTC_MINUTE_OSC_CYCLES = RTC_MINUTE_S * RTC_OSC_HZ;
  localparam logic [17:0] RTC_PER_1HZ       = 18'h08000;
  localparam logic [17:0] RTC_PER_4K        = 18'h00008;
  localparam logic [17:0] RTC_PER_8K        = 18'h00004;
  localparam logic [17:0] RTC_PER_32K       = 18'h00001;
  localparam logic [17:0] RTC_PER_CAL       = 18'h00200;
  localparam logic [17:0] RTC_PER_MIN       = 18'h00001;

  // ==========================================================================
  // Serial slave states
  // ==========================================================================
  typedef enum logic [3:0] {
    RTC_ST_IDLE  = 4'h0,
    RTC_ST_CTRL  = 4'h1,
    RTC_ST_CACK  = 4'h2,
    RTC_ST_ADDR  = 4'h3,
    RTC_ST_AACK  = 4'h4,
    RTC_ST_WDATA = 4'h5,
    RTC_ST_TX    = 4'h6,
    RTC_ST_MACK  = 4'h7
  } rtc_i2c_state_e;

endpackage

// ==== core/rtc_wave_if.sv ====
// Carrier between the register side and the oscillator-side wave generator
`timescale 1ns/10ps
`default_nettype none
interface rtc_wave_if;
  logic [2:0] rate_sel;
  logic [7:0] calib;
  logic       wave;
  modport ctl (output rate_sel, output calib, input wave);
  modport gen (input rate_sel, input calib, output wave);
endinterface
`default_nettype wire

// ==== core/rtc_sync2.sv ====
// Two-flop level synchroniser, one chain per bit
`timescale 1ns/10ps
`default_nettype none
module rtc_sync2 #(
  parameter int unsigned      WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  // ==========================================================================
  // Per-bit chains
  // ==========================================================================
  // The first stage feeds only the second; nothing else may look at it
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic meta_reg;
    logic sync_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_reg <= RST_VAL[i];
        sync_reg <= RST_VAL[i];
      end else begin
        meta_reg <= d_i[i];
        sync_reg <= meta_reg;
      end
    end
    assign q_o[i] = sync_reg;
  end
endmodule
`default_nettype wire

// ==== core/rtc_wave_gen.sv ====
// Divided and calibrated square-wave generator on the oscillator clock
`timescale 1ns/10ps
`default_nettype none
module rtc_wave_gen
  import rtc_pkg::*;
#(
  parameter int unsigned MINUTE_CYCLES = RTC_MINUTE_OSC_CYCLES
) (
  input  wire logic osc_clk_i,
  input  wire logic rst_n_i,
  rtc_wave_if.gen   wave_bus
);
  logic [10:0] cfg_s;
  logic [2:0]  rate;
  logic        cal_neg;
  logic [17:0] step2;
  logic [17:0] step4;
  logic [17:0] base;
  logic [17:0] len;
  logic [17:0] half;
  logic [17:0] cnt_reg;
  logic [20:0] minute_reg;
  logic        pending_reg;
  logic        adj_reg;
  logic        wave_reg;
  logic        period_end;
  logic        minute_end;

  // ==========================================================================
  // Configuration crossing
  // ==========================================================================
  // Settings are quasi-static; a change mid-period may give one odd period
  rtc_sync2 #(.WIDTH(11), .RST_VAL(11'h000)) u_cfg_sync (
    .clk_i   (osc_clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({wave_bus.rate_sel, wave_bus.calib}),
    .q_o     (cfg_s)
  );
  assign rate    = cfg_s[10:8];
  assign cal_neg = cfg_s[RTC_BIT_CAL_SIGN];
  assign step2   = {10'h000, cfg_s[6:0], 1'b0};  // [R20]
  assign step4   = {9'h000, cfg_s[6:0], 2'b00};

  // ==========================================================================
  // Period length and high time
  // ==========================================================================
  always_comb begin
    unique case (rate)
      3'b000:  base = RTC_PER_1HZ;
      3'b001:  base = RTC_PER_4K;
      3'b010:  base = RTC_PER_8K;
      3'b011:  base = RTC_PER_32K;
      default: base = RTC_PER_CAL;                // [R01]
    endcase
    if (rate[2]) begin
      // Continuous trim: every period is 2*(256 +/- 2*cal)
      len  = cal_neg ? base - step4 : base + step4; // [R02]
      half = {1'b0, len[17:1]};
    end else begin
      // Once-a-minute trim; high time stays, so duty shifts too
      half = {1'b0, base[17:1]};
      if (adj_reg && cal_neg) begin
        len = (step2 >= base) ? RTC_PER_MIN : base - step2; // [R03]
      end else if (adj_reg) begin
        len = base + step2;
      end else begin
        len = base;
      end
    end
  end

  assign period_end = (cnt_reg >= len - RTC_PER_MIN);
  assign minute_end = (minute_reg == 21'(MINUTE_CYCLES - 1));

  // Period counter; the trimmed period is armed at a period boundary
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= 18'h00000;
      adj_reg <= 1'b0;
    end else if (period_end) begin
      cnt_reg <= 18'h00000;
      adj_reg <= pending_reg && !rate[2];
    end else begin
      cnt_reg <= cnt_reg + 18'h00001;
    end
  end

  // Minute tick; a new tick wins over consumption in the same cycle
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      minute_reg  <= 21'h000000;
      pending_reg <= 1'b0;
    end else begin
      minute_reg <= minute_end ? 21'h000000 : minute_reg + 21'h000001;
      if (minute_end) begin
        pending_reg <= 1'b1;
      end else if (period_end) begin
        pending_reg <= 1'b0;
      end
    end
  end

  // Registered wave level
  always_ff @(posedge osc_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wave_reg <= 1'b0;
    end else begin
      wave_reg <= (cnt_reg < half);
    end
  end
  assign wave_bus.wave = wave_reg;
endmodule
`default_nettype wire

// ==== core/rtc_output_timestamp_sram_access.sv ====
// Output pin, power-fail time-stamps and serial register/memory access
//
// Overview of operation
// [R01] Rate-high bit selects 512-cycle 64 Hz wave
// [R02] 64 Hz period trimmed every cycle
// [R03] Negative trim on fast rates clamps, skews duty
// [R04] Pin: output level, alarm, or divided wave
// [R05] On battery only alarm output keeps working
// [R06] No serial access while running from battery
// [R07] Supply loss: capture time, set battery flag
// [R08] Supply return: capture time in second set
// [R09] Clearing battery flag clears both records
// [R10] Records trusted only with battery, oscillator running
// [R11] 64 user bytes at 0x20, undefined after power-up
// [R12] Word address above 5F is not acknowledged
// [R13] Byte write: control, address, data, each acked
// [R14] After write, pointer sits past written byte
// [R15] Current-address read sends byte at pointer
// [R16] Repeated start keeps pointer for random read
// [R17] Master ack requests next sequential byte
// [R18] Pointer increments per byte, wraps in block
// [R19] Clock registers and user memory wrap separately
// [R20] Calibration sign subtracts when set
// [R21] Divided wave needs square-wave enable bit
`timescale 1ns/10ps
`default_nettype none
module rtc_output_timestamp_sram_access
  import rtc_pkg::*;
#(
  parameter logic [6:0]  DEV_ADDR          = RTC_DEV_ADDR_DEF,
  parameter int unsigned MINUTE_OSC_CYCLES = RTC_MINUTE_OSC_CYCLES
) (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        oscillator_input_clk_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  input  wire logic        supply_good_i,
  input  wire logic [31:0] time_now_i,
  input  wire logic        alarm_level_i,
  output logic             multi_function_pin_o,
  output logic             multi_function_pin_oe_o
);
  logic [2:0]     pin_s;
  logic [1:0]     wave_s;
  logic           scl_s;
  logic           sda_s;
  logic           supply_ok;
  logic           scl_q_reg;
  logic           sda_q_reg;
  logic           supply_q_reg;
  logic           scl_rise;
  logic           scl_fall;
  logic           bus_start;
  logic           bus_stop;
  logic           supply_fail;
  logic           supply_back;
  rtc_i2c_state_e state_reg;
  logic [3:0]     cnt_reg;
  logic [7:0]     rx_reg;
  logic [7:0]     tx_reg;
  logic [6:0]     ptr_reg;
  logic           rw_reg;
  logic           mack_reg;
  logic           sda_oe_reg;
  logic           wr_fire;
  logic [7:0]     rd_data;
  logic [7:0]     mem [0:RTC_MEM_WORDS-1];
  logic [7:0]     control_reg;
  logic [7:0]     calib_reg;
  logic           batt_flag_reg;
  logic [31:0]    fail_rec_reg;
  logic [31:0]    rest_rec_reg;
  logic           flag_clear;
  logic           wave_sel;
  logic           mfp_level;
  logic           mfp_oe_reg;

  rtc_wave_if wave_bus ();

  // ==========================================================================
  // Pin synchronisers and edge detection
  // ==========================================================================
  // Bus lines idle high; supply starts low so power-up is no failure event
  rtc_sync2 #(.WIDTH(3), .RST_VAL(3'b110)) u_pin_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({scl_i, sda_i, supply_good_i}),
    .q_o     (pin_s)
  );
  assign scl_s     = pin_s[2];
  assign sda_s     = pin_s[1];
  assign supply_ok = pin_s[0];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q_reg    <= 1'b1;
      sda_q_reg    <= 1'b1;
      supply_q_reg <= 1'b0;
    end else begin
      scl_q_reg    <= scl_s;
      sda_q_reg    <= sda_s;
      supply_q_reg <= supply_ok;
    end
  end

  assign scl_rise    = scl_s && !scl_q_reg;
  assign scl_fall    = !scl_s && scl_q_reg;
  assign bus_start   = scl_s && scl_q_reg && !sda_s && sda_q_reg;
  assign bus_stop    = scl_s && scl_q_reg && sda_s && !sda_q_reg;
  assign supply_fail = !supply_ok && supply_q_reg;
  assign supply_back = supply_ok && !supply_q_reg;

  // ==========================================================================
  // Pointer arithmetic
  // ==========================================================================
  // Each block wraps on itself so a burst never leaks across
  function automatic logic [6:0] ptr_inc(input logic [6:0] p);
    if (p == RTC_ADDR_CLK_LAST) begin
      return RTC_ADDR_CLK_FIRST;                  // [R19]
    end else if (p == RTC_ADDR_SRAM_LAST) begin
      return RTC_ADDR_SRAM_BASE;                  // [R19]
    end else begin
      return p + 7'h01;                           // [R18]
    end
  endfunction

  // ==========================================================================
  // Serial slave
  // ==========================================================================
  // Write strobe at the falling edge that ends a data byte
  assign wr_fire = (state_reg == RTC_ST_WDATA) && scl_fall &&
                   (cnt_reg == RTC_BITS_PER_BYTE) && !bus_start && !bus_stop;

  // Protocol sequencer; the slave never stretches the clock
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg  <= RTC_ST_IDLE;
      cnt_reg    <= 4'h0;
      rx_reg     <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 7'h00;
      rw_reg     <= 1'b0;
      mack_reg   <= 1'b0;
      sda_oe_reg <= 1'b0;
    end else if (!supply_ok) begin
      state_reg  <= RTC_ST_IDLE;                  // [R06]
      sda_oe_reg <= 1'b0;
    end else if (bus_start) begin
      state_reg  <= RTC_ST_CTRL;                  // [R16]
      cnt_reg    <= 4'h0;
      sda_oe_reg <= 1'b0;
    end else if (bus_stop) begin
      state_reg  <= RTC_ST_IDLE;
      sda_oe_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        RTC_ST_IDLE: begin
        end
        RTC_ST_CTRL, RTC_ST_ADDR, RTC_ST_WDATA: begin
          if (scl_rise && cnt_reg < RTC_BITS_PER_BYTE) begin
            rx_reg  <= {rx_reg[6:0], sda_s};
            cnt_reg <= cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == RTC_BITS_PER_BYTE) begin
            cnt_reg <= 4'h0;
            if (state_reg == RTC_ST_CTRL) begin
              if (rx_reg[7:1] == DEV_ADDR) begin
                sda_oe_reg <= 1'b1;               // [R13]
                rw_reg     <= rx_reg[0];
                state_reg  <= RTC_ST_CACK;
              end else begin
                state_reg  <= RTC_ST_IDLE;
              end
            end else if (state_reg == RTC_ST_ADDR) begin
              if (rx_reg <= RTC_ADDR_MAX) begin
                sda_oe_reg <= 1'b1;
                ptr_reg    <= rx_reg[6:0];        // [R13]
                state_reg  <= RTC_ST_AACK;
              end else begin
                state_reg  <= RTC_ST_IDLE;        // [R12]
              end
            end else begin
              sda_oe_reg <= 1'b1;
              ptr_reg    <= ptr_inc(ptr_reg);     // [R14]
              state_reg  <= RTC_ST_AACK;
            end
          end
        end
        RTC_ST_CACK: begin
          if (scl_fall && rw_reg) begin
            tx_reg     <= rd_data;                // [R15]
            sda_oe_reg <= !rd_data[7];
            ptr_reg    <= ptr_inc(ptr_reg);       // [R18]
            cnt_reg    <= 4'h0;
            state_reg  <= RTC_ST_TX;
          end else if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= RTC_ST_ADDR;
          end
        end
        RTC_ST_AACK: begin
          if (scl_fall) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= RTC_ST_WDATA;
          end
        end
        RTC_ST_TX: begin
          if (scl_fall && cnt_reg == RTC_LAST_TX_BIT) begin
            sda_oe_reg <= 1'b0;
            state_reg  <= RTC_ST_MACK;
          end else if (scl_fall) begin
            tx_reg     <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= !tx_reg[6];
            cnt_reg    <= cnt_reg + 4'h1;
          end
        end
        RTC_ST_MACK: begin
          if (scl_rise) begin
            mack_reg <= !sda_s;
          end else if (scl_fall && mack_reg) begin
            tx_reg     <= rd_data;                // [R17]
            sda_oe_reg <= !rd_data[7];
            ptr_reg    <= ptr_inc(ptr_reg);
            cnt_reg    <= 4'h0;
            state_reg  <= RTC_ST_TX;
          end else if (scl_fall) begin
            state_reg  <= RTC_ST_IDLE;
          end
        end
      endcase
    end
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = sda_oe_reg;

  // ==========================================================================
  // Register and memory storage
  // ==========================================================================
  // No reset on the array: user memory is undefined after power-up
  always_ff @(posedge mclk_i) begin
    if (wr_fire) begin
      mem[ptr_reg] <= rx_reg;                     // [R11]
    end
  end

  // Read view; special locations override the plain array
  always_comb begin
    rd_data = mem[ptr_reg];
    if (ptr_reg == RTC_ADDR_STATUS) begin
      rd_data[RTC_BIT_BATTERY] = batt_flag_reg;
    end else if (ptr_reg == RTC_ADDR_CONTROL) begin
      rd_data = control_reg;
    end else if (ptr_reg == RTC_ADDR_CALIB) begin
      rd_data = calib_reg;
    end else if (ptr_reg[6:2] == RTC_ADDR_FAIL_REC[6:2]) begin
      rd_data = fail_rec_reg[{ptr_reg[1:0], 3'b000} +: 8];
    end else if (ptr_reg[6:2] == RTC_ADDR_REST_REC[6:2]) begin
      rd_data = rest_rec_reg[{ptr_reg[1:0], 3'b000} +: 8];
    end
  end

  // Control and calibration registers
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      control_reg <= RTC_CONTROL_RST;
      calib_reg   <= RTC_CALIB_RST;
    end else if (wr_fire && ptr_reg == RTC_ADDR_CONTROL) begin
      control_reg <= rx_reg;
    end else if (wr_fire && ptr_reg == RTC_ADDR_CALIB) begin
      calib_reg   <= rx_reg;                      // [R20]
    end
  end

  // ==========================================================================
  // Power-fail time-stamps
  // ==========================================================================
  // Restore capture only follows a recorded failure, not first power-up
  assign flag_clear = wr_fire && ptr_reg == RTC_ADDR_STATUS &&
                      !rx_reg[RTC_BIT_BATTERY];

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      batt_flag_reg <= 1'b0;
      fail_rec_reg  <= RTC_RECORD_RST;
      rest_rec_reg  <= RTC_RECORD_RST;
    end else if (supply_fail) begin
      batt_flag_reg <= 1'b1;                      // [R07]
      fail_rec_reg  <= time_now_i;                // [R07]
    end else if (supply_back && batt_flag_reg) begin
      rest_rec_reg  <= time_now_i;                // [R08]
    end else if (flag_clear) begin
      batt_flag_reg <= 1'b0;
      fail_rec_reg  <= RTC_RECORD_RST;            // [R09]
      rest_rec_reg  <= RTC_RECORD_RST;            // [R09]
    end
  end

  // ==========================================================================
  // Multi-function pin
  // ==========================================================================
  assign wave_bus.rate_sel = control_reg[2:0];
  assign wave_bus.calib    = calib_reg;

  rtc_wave_gen #(.MINUTE_CYCLES(MINUTE_OSC_CYCLES)) u_wave_gen (
    .osc_clk_i (oscillator_input_clk_i),
    .rst_n_i   (rst_n_i),
    .wave_bus  (wave_bus.gen)
  );

  // Wave and raw oscillator level cross back as plain levels
  rtc_sync2 #(.WIDTH(2), .RST_VAL(2'b00)) u_wave_sync (
    .clk_i   (mclk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({wave_bus.wave, oscillator_input_clk_i}),
    .q_o     (wave_s)
  );

  // Full-rate setting passes the oscillator itself, untrimmed
  assign wave_sel = (control_reg[2:0] == 3'b011) ? wave_s[0] : wave_s[1];

  // Pin selection; alarm first since it alone survives battery mode
  always_comb begin
    if (control_reg[RTC_BIT_ALARM_HI:RTC_BIT_ALARM_LO] != 2'b00) begin
      mfp_level = alarm_level_i;                  // [R04]
    end else if (!supply_ok) begin
      mfp_level = 1'b1;                           // [R05]
    end else if (control_reg[RTC_BIT_SQUARE_WAVE_ENABLE]) begin
      mfp_level = wave_sel;                       // [R21]
    end else begin
      mfp_level = control_reg[RTC_BIT_OUT_LEVEL]; // [R04]
    end
  end

  // Open drain: enable pulls low, released line reads high
  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mfp_oe_reg <= 1'b0;
    end else begin
      mfp_oe_reg <= !mfp_level;
    end
  end

  assign multi_function_pin_o    = 1'b0;
  assign multi_function_pin_oe_o = mfp_oe_reg;
endmodule
`default_nettype wire

// ==== sim/rtc_ports_sva.sv ====
// Port assertions for serial answers, pin drive and supply loss
`timescale 1ns/10ps
`default_nettype none
module rtc_ports_sva (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic supply_good_i,
  input wire logic multi_function_pin_o,
  input wire logic multi_function_pin_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========================================================
  // Open-drain pins never drive high
  sda_low_a: assert property (sda_o == 1'b0)
    else $error("sda driven high");
  pin_low_a: assert property (multi_function_pin_o == 1'b0)
    else $error("pin driven high");
  // ==========================================================
  // No answer on battery; answers move only while SCL is low
  batt_quiet_a: assert property (!supply_good_i [*8] |-> !sda_oe_o)
    else $error("sda pulled in battery mode");
  fail_drop_a: assert property ($fell(supply_good_i) |-> ##[1:6] !sda_oe_o)
    else $error("sda not released on supply loss");
  ack_supply_a: assert property ($rose(sda_oe_o) |-> $past(supply_good_i, 3))
    else $error("answer raised without supply");
  oe_edge_a: assert property ($changed(sda_oe_o) |-> !scl_i && !$past(scl_i, 2))
    else $error("sda drive changed near SCL high");
  oe_hold_a: assert property (scl_i [*4] |-> $stable(sda_oe_o))
    else $error("sda drive moved while SCL high");
  rst_quiet_a: assert property ($rose(rst_n_i) |-> !sda_oe_o && !multi_function_pin_oe_o)
    else $error("pins pulled right after reset");
  // Main scenarios reached
  cover property ($rose(sda_oe_o));
  cover property ($fell(supply_good_i));
  cover property ($rose(multi_function_pin_oe_o));
endmodule
bind rtc_output_timestamp_sram_access rtc_ports_sva u_sva (
  .mclk_i, .rst_n_i, .scl_i, .sda_o, .sda_oe_o, .supply_good_i,
  .multi_function_pin_o, .multi_function_pin_oe_o);
`default_nettype wire

// ==== sim/rtc_master.sv ====
// Two-wire bus master model on the far side of the serial pins
`timescale 1ns/10ps
`default_nettype none
module rtc_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var logic  scl_o,
  output var logic  sda_pull_o
);
  logic [7:0] res;
  logic       ak;
  event       ev;
  // Bus idles released; SCL stands high between frames
  initial begin
    scl_o = 1'b1;
    sda_pull_o = 1'b0;
  end
  // 12 cycles keeps each SCL phase well past the pin sync delay
  task automatic qb();
    repeat (12) @(negedge clk_i);
  endtask
  task automatic bit_x(input logic d, output logic s);
    sda_pull_o = !d;
    qb();
    scl_o = 1'b1;
    qb();
    s = sda_i;
    scl_o = 1'b0;
    qb();
  endtask
  // Start (also repeated) or stop condition
  task automatic cond(input logic st);
    sda_pull_o = !st;
    qb();
    scl_o = 1'b1;
    qb();
    sda_pull_o = st;
    qb();
    scl_o = !st;
    qb();
  endtask
  // Byte MSB first; res is what the line carried, ak the ninth bit inverted
  task automatic xb(input logic [7:0] b, input logic a);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
      res[i] = s;
    end
    bit_x(!a, s);
    ak = !s;
    -> ev;
  endtask
endmodule
`default_nettype wire

// ==== sim/testbench.sv ====
// Bench: serial access, pin output and power-fail time-stamps
`timescale 1ns/10ps
`default_nettype none
module testbench;
  import rtc_pkg::*;
  logic        mclk = 1'b0;
  logic        osc = 1'b0, alarm = 1'b0;
  logic        rst_n, supply, sda_oe, pin_oe;
  logic [31:0] tnow;
  logic [63:0] ts;
  logic [15:0] seen, exp_q[$];
  logic [7:0]  d0, d1;
  int          fail_count, total_checks, cyc;
  wire         scl, pull;
  wire         sda = !(pull | sda_oe);
  event        pev;
  localparam logic [7:0] CW = {RTC_DEV_ADDR_DEF, 1'b0};
  localparam logic [7:0] CR = {RTC_DEV_ADDR_DEF, 1'b1};
  rtc_output_timestamp_sram_access #(.MINUTE_OSC_CYCLES(64)) uut (
    .mclk_i(mclk), .rst_n_i(rst_n), .oscillator_input_clk_i(osc),
    .scl_i(scl), .sda_i(sda), .sda_o(), .sda_oe_o(sda_oe),
    .supply_good_i(supply), .time_now_i(tnow), .alarm_level_i(alarm),
    .multi_function_pin_o(), .multi_function_pin_oe_o(pin_oe));
  rtc_master m (.clk_i(mclk), .sda_i(sda), .scl_o(scl), .sda_pull_o(pull));
  // Clocks; the oscillator is offset so its phase is unrelated
  always #2 mclk = ~mclk;
  initial #5.3 forever #16 osc = ~osc;
  task automatic chk(input string n, input logic [15:0] s);
    logic [15:0] e;
    e = exp_q.pop_front();
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Result watchers take the oldest note
  always @(m.ev) chk("bus byte", {7'h00, m.res, m.ak});
  always @(pev) chk("pin", seen);
  task automatic cnd(input logic s); m.cond(s); endtask
  task automatic wb(input logic [7:0] b, input logic a);
    exp_q.push_back({7'h00, b, a});
    m.xb(b, 1'b0);
  endtask
  task automatic rb(input logic [7:0] d, input logic a);
    exp_q.push_back({7'h00, d, a});
    m.xb(8'hFF, a);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    cnd(1'b1);
    wb(CW, 1'b1);
    wb(a, 1'b1);
    wb(d, 1'b1);
    cnd(1'b0);
  endtask
  // Random read of n bytes, byte i expected in v[8i+7:8i]
  task automatic rd(input logic [7:0] a, input int n, input logic [63:0] v);
    cnd(1'b1);
    wb(CW, 1'b1);
    wb(a, 1'b1);
    cnd(1'b1);
    wb(CR, 1'b1);
    for (int i = 0; i < n; i++) rb(v[8*i+:8], i < n - 1);
    cnd(1'b0);
  endtask
  // Pin pull-down enable, or wave period rounded to oscillator cycles
  task automatic pin(input logic [15:0] e, input bit wave);
    realtime t;
    repeat (40) @(negedge mclk);
    t = $realtime;
    if (wave) begin
      repeat (2) @(posedge pin_oe);
      t = $realtime;
      @(posedge pin_oe);
    end
    exp_q.push_back(e);
    seen = {15'h0, pin_oe};
    if (wave) seen = 16'($rtoi(($realtime - t) / 32.0 + 0.5));
    @(negedge mclk);
    -> pev;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // Ceiling well above the expected run of about 53000 cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      finish_test();
    end
  end
  initial begin
    rst_n = 1'b0;
    supply = 1'b1;
    tnow = 32'h0;
    void'($urandom(23));
    // Long enough to cover two oscillator edges as well
    repeat (16) @(negedge mclk);
    rst_n = 1'b1;
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    repeat (8) @(negedge mclk);
    wr(8'h20, d0);
    wr(8'h5F, d1);
    cnd(1'b1);
    wb(CR, 1'b1);
    rb(d0, 1'b0);
    cnd(1'b0);
    rd(8'h5F, 2, {48'h0, d0, d1});
    cnd(1'b1);
    wb(CW, 1'b1);
    wb(8'h60, 1'b0);
    cnd(1'b0);
    $display("test done: serial access");
    wr(RTC_ADDR_CONTROL, 8'h00);
    pin(16'h1, 1'b0);
    wr(RTC_ADDR_CONTROL, 8'h80);
    pin(16'h0, 1'b0);
    wr(RTC_ADDR_CONTROL, 8'hB0);
    pin(16'h1, 1'b0);
    wr(RTC_ADDR_CONTROL, 8'h44);
    pin(16'd512, 1'b1);
    wr(RTC_ADDR_CALIB, 8'h05);
    pin(16'd532, 1'b1);
    wr(RTC_ADDR_CALIB, 8'h85);
    pin(16'd492, 1'b1);
    wr(RTC_ADDR_CONTROL, 8'h00);
    $display("test done: pin output");
    ts = {$urandom, $urandom};
    tnow = ts[31:0];
    supply = 1'b0;
    pin(16'h0, 1'b0);
    cnd(1'b1);
    wb(CW, 1'b0);
    cnd(1'b0);
    tnow = ts[63:32];
    supply = 1'b1;
    rd(RTC_ADDR_FAIL_REC, 8, ts);
    wr(RTC_ADDR_STATUS, 8'h00);
    rd(RTC_ADDR_FAIL_REC, 8, 64'h0);
    $display("test done: time-stamps");
    finish_test();
  end
endmodule
`default_nettype wire
